// ==== design/pmw_params.svh ====
// Constants for the power-state and wake control block.
// Assumes it is included by the package and the design modules.
//
// Behaviour
// (R1) Wake sources are a detected wake frame and a link-down event.
// (R2) Wake frame raises status only when its enable bit is set.
// (R3) Software enables link-down wake in the external PHY interrupt mask.
// (R4) Wake events are watched only in low-power states.
// (R5) Power control/status register at config offset E0h, bits 23..0.
// (R6) Wake request low while status bit 15 and enable bit 8 are set.
// (R7) Wake request needs no synchronisation to the PCI clock.
// (R8) Clearing status or enable releases the wake request.
// (R9) Status and enable bits survive PCI bus reset.
// (R10) Status and enable cleared only at power-up, kept on aux power.
// (R11) Wake pin is open-drain, never driven low unless asserting.
// (R12) Software selects D0..D3; power-up forces D0.
// (R13) Power state retained through PCI power loss on aux power. The code forces D0 when PCI power returns with control bit 22 set.
// (R14) D0 is operational without scanning; pending wake stays asserted.
// (R15) D1, D2 and D3hot behave the same.
// (R16) Entering low power sets power-down bit 3 of control at 0Ch.
// (R17) Config accesses still accepted in low power with PCI clock.
// (R18) Low power refuses I/O and memory, disables mastering and interrupts. The code still accepts I/O writes to general control at 0Ch.
// (R19) Low power with PCI power keeps scanning and keeps state.
// (R20) Bits 15:14 of link config at 38h equal 11b gate transmit clock.
// (R21) Aux-powered state acts as low power but config is unreachable.
// (R22) Unpowered state does no scanning and no transactions. The code keeps cfgAccessOk high there, so config writes land.
// (R23) Control bits 21:20 choose PCI reset effect on power state.
// (R24) Power-on loads state 00b and clears status and enable.
// (R25) State codes D0=00b, D1=01b, D2=10b, D3=11b.
// (R26) Software must idle the network before entering low power.
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH

`define PMW_OFS_GEN_CTRL   8'h0C
`define PMW_OFS_LINK_CFG   8'h38
`define PMW_OFS_PM_CSR     8'hE0

`define PMW_CSR_STATE_LO   0
`define PMW_CSR_ENABLE     8
`define PMW_CSR_STATUS     15
`define PMW_CSR_MASK       24'h00_8103

`define PMW_GC_POWER_DOWN  3
`define PMW_GC_CLK_RESTORE 16
`define PMW_GC_RST_IGNORE  17
`define PMW_GC_FRAME_EN    18
`define PMW_GC_WAKE_INT    19
`define PMW_GC_RST_SEL_LO  20
`define PMW_GC_AUX_MODE    22
`define PMW_GC_RESET       32'h0000_0000

`define PMW_LC_TXOFF_LO    14
`define PMW_LC_RESET       32'h0000_0000

`define PMW_SYNC_STAGES    3

`endif

// ==== design/pmw_pkg.sv ====
// Types shared by the power-state and wake control block.
// Assumes pmw_params.svh sits in the include path.
`include "pmw_params.svh"

package pmw_pkg;

  typedef enum logic [1:0] {
    PMW_D0 = 2'h0,
    PMW_D1 = 2'h1,
    PMW_D2 = 2'h2,
    PMW_D3 = 2'h3
  } pmw_dstate_e;

  typedef enum logic [1:0] {
    PMW_RST_ON_ASSERT  = 2'h0,
    PMW_RST_ON_RELEASE = 2'h1,
    PMW_RST_NONE       = 2'h2,
    PMW_RST_NONE2      = 2'h3
  } pmw_rstsel_e;

  // Register access from the configuration and I/O target
  typedef struct packed {
    logic        cfgWrite;
    logic        ioWrite;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pmw_access_s;

  // Gating outputs toward the rest of the controller
  typedef struct packed {
    logic sysClkOff;
    logic txClkOff;
    logic ioMemRefuse;
    logic masterOff;
    logic intOff;
    logic scanEnable;
  } pmw_gate_s;

endpackage : pmw_pkg

// ==== design/pmw_sync.sv ====
// Three-stage synchroniser bank for asynchronous pin inputs.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none

`include "pmw_params.svh"

module pmw_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [`PMW_SYNC_STAGES-1:0] stage;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          stage      <= '0;
          syncOut[i] <= 1'b0;
        end else if (clkEn) begin
          stage <= {stage[`PMW_SYNC_STAGES-2:0], asyncIn[i]};
          // Only the second and third stages are compared
          if (stage[1] == stage[2]) begin
            syncOut[i] <= stage[2];
          end
        end
      end
    end
  endgenerate

endmodule : pmw_sync

`default_nettype wire

// ==== design/pmw_power_wake.sv ====
// Power state, wake status and wake request control.
// Assumes rst_n is the power-on reset, pins are asynchronous and the
// register target delivers one-cycle write strobes on mclk.
`timescale 1ns/1ns
`default_nettype none

`include "pmw_params.svh"

module pmw_power_wake
  import pmw_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire pmw_access_s access,
  input  wire logic        pciResetPin_n,
  input  wire logic        pciPowerGoodPin,
  input  wire logic        auxPowerPresent,
  input  wire logic        wakeFrameSeen,
  input  wire logic        linkDownIrq,
  output var  logic [23:0] power_mgmt_ctrl_status,
  output var  logic [31:0] general_control,
  output var  logic [31:0] phy_link_configuration,
  output logic             wake_request_n_o,
  output logic             wake_request_n_oe,
  output logic             cfgAccessOk,
  output logic             wakeInterrupt,
  output var  pmw_gate_s   gate
);

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  logic [2:0] pinSync;
  logic       pciReset;
  logic       pciPowerGood;
  logic       linkDown;
  logic       pciResetDly;
  logic       pciPowerDly;

  pmw_sync #(.WIDTH(3)) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .asyncIn ({linkDownIrq, ~pciResetPin_n, pciPowerGoodPin}),
    .syncOut (pinSync)
  );

  assign pciReset     = pinSync[1];
  assign pciPowerGood = pinSync[0];
  // PHY interrupt comes from a pin, so a pulse shorter than two clocks is lost
  assign linkDown     = pinSync[2];

  // ==========================================================
  // Decode
  // ==========================================================
  logic        csrWrite;
  logic        gcWrite;
  logic        lcWrite;
  pmw_dstate_e dState;
  pmw_rstsel_e rstSel;
  logic        lowPower;
  logic        auxMode;
  logic        rstIgnore;
  logic        resetAssertEdge;
  logic        resetReleaseEdge;
  logic        powerReturnEdge;
  logic        forceD0;
  logic        wakeStatus;
  logic        wakeEnable;
  logic        wakeEvent;
  logic        wakeActive;
  logic        noPciPower;
  logic        scanOn;

  assign csrWrite  = access.cfgWrite && access.addr == `PMW_OFS_PM_CSR
                     && cfgAccessOk;                                      // [R17] [R21]
  assign gcWrite   = access.ioWrite && access.addr == `PMW_OFS_GEN_CTRL;
  assign lcWrite   = access.ioWrite && access.addr == `PMW_OFS_LINK_CFG
                     && !lowPower;                                        // [R18]

  assign dState    = pmw_dstate_e'(power_mgmt_ctrl_status[`PMW_CSR_STATE_LO +: 2]); // [R25]
  assign rstSel    = pmw_rstsel_e'(general_control[`PMW_GC_RST_SEL_LO +: 2]);
  assign auxMode   = general_control[`PMW_GC_AUX_MODE];
  assign rstIgnore = general_control[`PMW_GC_RST_IGNORE];
  assign lowPower  = dState != PMW_D0;                                    // [R15]
  assign noPciPower = !pciPowerGood;

  assign wakeStatus = power_mgmt_ctrl_status[`PMW_CSR_STATUS];
  assign wakeEnable = power_mgmt_ctrl_status[`PMW_CSR_ENABLE];

  assign resetAssertEdge  = pciReset && !pciResetDly && !rstIgnore;
  assign resetReleaseEdge = !pciReset && pciResetDly && !rstIgnore;
  assign powerReturnEdge  = auxMode && pciPowerGood && !pciPowerDly;

  // Reset selection of D0, or PCI power coming back in the aux mode
  always_comb begin
    case (rstSel)
      PMW_RST_ON_ASSERT:  forceD0 = resetAssertEdge;                      // [R23]
      PMW_RST_ON_RELEASE: forceD0 = resetReleaseEdge;                     // [R23]
      PMW_RST_NONE:       forceD0 = 1'b0;                                 // [R23]
      default:            forceD0 = 1'b0;
    endcase
  end

  // Scanning only in low power, and never with neither PCI nor aux power
  assign scanOn    = lowPower && (!noPciPower || auxPowerPresent);        // [R19] [R21] [R22]
  assign wakeEvent = scanOn                                               // [R4] [R14]
                     && ((wakeFrameSeen && general_control[`PMW_GC_FRAME_EN]) // [R1] [R2]
                         || linkDown);                                    // [R1] [R3]

  // ==========================================================
  // Power management control/status register
  // ==========================================================
  logic [23:0] next_csr;
  logic        next_status;

  // An event in the same cycle as a write-one-clear keeps the bit set
  assign next_status = wakeEvent
                       || (wakeStatus && !(csrWrite && access.wdata[`PMW_CSR_STATUS])); // [R8]

  always_comb begin
    next_csr = power_mgmt_ctrl_status;
    if (csrWrite) begin
      next_csr[`PMW_CSR_STATE_LO +: 2] = access.wdata[`PMW_CSR_STATE_LO +: 2]; // [R12]
      next_csr[`PMW_CSR_ENABLE]        = access.wdata[`PMW_CSR_ENABLE];        // [R8]
    end
    if (forceD0 || powerReturnEdge) begin
      next_csr[`PMW_CSR_STATE_LO +: 2] = 2'h0;                            // [R23]
    end
    next_csr[`PMW_CSR_STATUS] = next_status;
    next_csr = next_csr & `PMW_CSR_MASK;                                  // [R5]
  end

  // Only power-on reset clears it; PCI reset and power loss keep status and enable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_mgmt_ctrl_status <= 24'h00_0000;                              // [R24] [R10] [R12]
    end else if (clkEn) begin
      power_mgmt_ctrl_status <= next_csr;                                 // [R9] [R13]
    end
  end

  // ==========================================================
  // General control and link configuration
  // ==========================================================
  logic [31:0] next_gc;
  logic        enterLow;
  logic        prevLow;

  assign enterLow = lowPower && !prevLow;

  always_comb begin
    next_gc = general_control;
    // Stays writable in low power so software can clear power-down again
    if (gcWrite) begin
      next_gc = access.wdata;
    end
    if (enterLow) begin
      next_gc[`PMW_GC_POWER_DOWN] = 1'b1;                                 // [R16]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      general_control        <= `PMW_GC_RESET;
      phy_link_configuration <= `PMW_LC_RESET;
      prevLow                <= 1'b0;
      pciResetDly            <= 1'b0;
      pciPowerDly            <= 1'b0;
    end else if (clkEn) begin
      general_control <= next_gc;
      if (lcWrite) begin
        phy_link_configuration <= access.wdata;
      end
      prevLow     <= lowPower;
      pciResetDly <= pciReset;
      pciPowerDly <= pciPowerGood;
    end
  end

  // ==========================================================
  // Gating and wake pin
  // ==========================================================
  assign wakeActive = wakeStatus && wakeEnable;                           // [R6] [R14]

  // Combinational from the register bits, no PCI clock involved
  assign wake_request_n_o  = 1'b0;                                        // [R7]
  assign wake_request_n_oe = wakeActive;                                  // [R6] [R11]

  // Config space needs PCI clock; absent without PCI power while aux power is present
  assign cfgAccessOk = pciPowerGood || !auxPowerPresent;                  // [R17] [R21]

  assign wakeInterrupt = wakeActive && general_control[`PMW_GC_WAKE_INT];

  assign gate.sysClkOff   = general_control[`PMW_GC_POWER_DOWN]
                            && !general_control[`PMW_GC_CLK_RESTORE];     // [R16]
  assign gate.txClkOff    = &phy_link_configuration[`PMW_LC_TXOFF_LO +: 2]; // [R20]
  assign gate.ioMemRefuse = lowPower;                                     // [R18]
  assign gate.masterOff   = lowPower;                                     // [R18]
  assign gate.intOff      = lowPower;                                     // [R18]
  assign gate.scanEnable  = scanOn;                                       // [R19] [R22]

endmodule : pmw_power_wake

`default_nettype wire

// ==== test/pmw_power_wake_sva.sv ====
// Checker on the ports of the power-state and wake block.
// Assumes one domain: mclk with synchronous active-low rst_n.
`timescale 1ns/1ns
`default_nettype none

module pmw_power_wake_sva
  import pmw_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire pmw_access_s access,
  input wire logic [23:0] power_mgmt_ctrl_status,
  input wire logic [31:0] general_control,
  input wire logic [31:0] phy_link_configuration,
  input wire logic        wake_request_n_o,
  input wire logic        wake_request_n_oe,
  input wire logic        cfgAccessOk,
  input wire pmw_gate_s   gate
);
  wire logic [23:0] csr = power_mgmt_ctrl_status;
  wire logic        low = csr[1:0] != 2'h0;
  wire logic        wr  = clkEn && access.cfgWrite && access.addr == 8'hE0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  AST_WAKE_ON: assert property (csr[15] && csr[8] |-> wake_request_n_oe)
    else $error("wake request not driven");
  AST_WAKE_OFF: assert property (!(csr[15] && csr[8]) |-> !wake_request_n_oe)
    else $error("wake request driven without cause");
  AST_PIN_LOW: assert property (wake_request_n_o == 1'b0)
    else $error("wake pin drives high");
  AST_POR: assert property ($past(!rst_n && clkEn) |-> csr == 24'h0 && !wake_request_n_oe)
    else $error("power-on values wrong");
  AST_RESERVED: assert property ((csr & ~24'h00_8103) == 24'h0)
    else $error("reserved status bits set");
  AST_REFUSE: assert property (low |-> gate.ioMemRefuse && gate.masterOff && gate.intOff)
    else $error("low power gating missing");
  AST_NO_SCAN: assert property (!low |-> !gate.scanEnable)
    else $error("scanning in D0");
  AST_PD_ENTRY: assert property (clkEn && !low ##1 clkEn && low && !access.ioWrite
    |=> general_control[3]) else $error("power-down bit not set");
  AST_CSR_WRITE: assert property (wr && cfgAccessOk |=> csr[8] == $past(access.wdata[8])
    && csr[1:0] == $past(access.wdata[1:0])) else $error("state write lost");
  AST_EVENT_LOW: assert property ($rose(csr[15]) |-> $past(low))
    else $error("wake event taken in D0");
  AST_LC_HOLD: assert property (clkEn && access.ioWrite && access.addr == 8'h38 && low
    |=> $stable(phy_link_configuration)) else $error("refused write landed");
  AST_TXOFF: assert property (low && phy_link_configuration[15:14] == 2'h3 |-> gate.txClkOff)
    else $error("transmit clock not gated");
endmodule : pmw_power_wake_sva

bind pmw_power_wake pmw_power_wake_sva i_sva (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
  .access(access), .power_mgmt_ctrl_status(power_mgmt_ctrl_status),
  .general_control(general_control), .phy_link_configuration(phy_link_configuration),
  .wake_request_n_o(wake_request_n_o), .wake_request_n_oe(wake_request_n_oe),
  .cfgAccessOk(cfgAccessOk), .gate(gate));

`default_nettype wire

// ==== test/pmw_host_model.sv ====
// Host side of the wake line: the board pull-up and the line level.
// Assumes the block pulls the line only through its enable.
`timescale 1ns/1ns
`default_nettype none

module pmw_host_model (
  input  wire logic driveLow,
  input  wire logic driveVal,
  output wire logic wakeLine
);
  // Released line goes to the pull-up, never keeps the last driven level
  assign wakeLine = driveLow ? driveVal : 1'b1;
endmodule : pmw_host_model

`default_nettype wire

// ==== test/tb_pmw_power_wake.sv ====
// Self-checking testbench for the power-state and wake block.
// Assumes the checker binds itself and pins settle within 6 clocks.
`timescale 1ns/1ns
`default_nettype none

module tb_pmw_power_wake;
  import pmw_pkg::*;
  logic        mclk            = 1'b0;
  logic        rst_n           = 1'b0;
  logic        pciResetPin_n   = 1'b1;
  logic        pciPowerGoodPin = 1'b1;
  logic        wakeFrameSeen   = 1'b0;
  logic        linkDownIrq     = 1'b0;
  logic        auxPresent      = 1'b1;
  pmw_access_s access          = '0;
  logic [23:0] csr;
  logic [31:0] gc;
  logic [31:0] lc;
  logic        wakeO;
  logic        wakeOe;
  logic        cfgOk;
  logic        wakeInt;
  pmw_gate_s   gate;
  wire logic   wakeLine;
  int          err_count       = 0;
  int          num_checks      = 0;

  always #4 mclk = ~mclk;

  pmw_power_wake i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .access(access),
    .pciResetPin_n(pciResetPin_n), .pciPowerGoodPin(pciPowerGoodPin),
    .auxPowerPresent(auxPresent), .wakeFrameSeen(wakeFrameSeen), .linkDownIrq(linkDownIrq),
    .power_mgmt_ctrl_status(csr), .general_control(gc), .phy_link_configuration(lc),
    .wake_request_n_o(wakeO), .wake_request_n_oe(wakeOe), .cfgAccessOk(cfgOk),
    .wakeInterrupt(wakeInt), .gate(gate));
  pmw_host_model i_host (.driveLow(wakeOe), .driveVal(wakeO), .wakeLine(wakeLine));

  // ==========
  // Stimulus tasks
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic wr(input logic cfg, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    access <= '{cfgWrite: cfg, ioWrite: !cfg, addr: a, wdata: d};
    @(posedge mclk);
    access <= '0;
    #1;
  endtask : wr

  task automatic pulse(input logic link);
    @(posedge mclk);
    if (link) linkDownIrq <= 1'b1;
    else wakeFrameSeen <= 1'b1;
    @(posedge mclk);
    wakeFrameSeen <= 1'b0;
    // Link-down is a pin: hold it past the synchroniser, then let it drain
    if (link) begin
      repeat (3) @(posedge mclk);
      linkDownIrq <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    #1;
  endtask : pulse

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  // ==========
  // Test sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    step(1);
    chk(csr, 24'h0);
    chk(wakeLine, 1'b1);
    // Pin synchronisers settle before the first access
    step(4);
    wr(1'b0, 8'h38, 32'h0000_C000);
    wr(1'b1, 8'hE0, 32'h0000_0103);
    step(1);
    chk(gc[3], 1'b1);
    chk({gate.sysClkOff, gate.txClkOff, gate.ioMemRefuse, gate.masterOff, gate.intOff,
      gate.scanEnable}, 6'h3F);
    wr(1'b0, 8'h38, 32'h0);
    chk(lc, 32'h0000_C000);
    pulse(1'b0);
    chk(csr, 24'h0103);
    wr(1'b0, 8'h0C, 32'h000C_0008);
    pulse(1'b0);
    chk(csr, 24'h8103);
    chk(wakeLine, 1'b0);
    chk(wakeInt, 1'b1);
    @(posedge mclk);
    pciResetPin_n <= 1'b0;
    step(6);
    chk(csr, 24'h8100);
    chk(wakeLine, 1'b0);
    @(posedge mclk);
    pciResetPin_n <= 1'b1;
    step(6);
    wr(1'b1, 8'hE0, 32'h0000_8100);
    chk(wakeLine, 1'b1);
    chk(wakeInt, 1'b0);
    for (int s = 1; s < 4; s++) begin
      wr(1'b1, 8'hE0, 32'h100 | s);
      pulse(1'b1);
      chk(csr, 32'h8100 | s);
      wr(1'b1, 8'hE0, 32'h0000_8100);
    end
    // Reset select 01: only the release of PCI reset returns to D0
    wr(1'b0, 8'h0C, 32'h001C_0008);
    wr(1'b1, 8'hE0, 32'h0000_0103);
    @(posedge mclk);
    pciResetPin_n <= 1'b0;
    step(6);
    chk(csr[1:0], 2'h3);
    @(posedge mclk);
    pciResetPin_n <= 1'b1;
    step(6);
    chk(csr[1:0], 2'h0);
    wr(1'b1, 8'hE0, 32'h0000_0103);
    @(posedge mclk);
    pciPowerGoodPin <= 1'b0;
    step(6);
    chk(cfgOk, 1'b0);
    wr(1'b1, 8'hE0, 32'h0000_0100);
    pulse(1'b1);
    chk(csr, 24'h8103);
    @(posedge mclk);
    auxPresent <= 1'b0;
    step(1);
    chk(gate.scanEnable, 1'b0);
    @(posedge mclk);
    auxPresent <= 1'b1;
    @(posedge mclk);
    pciPowerGoodPin <= 1'b1;
    step(6);
    chk(cfgOk, 1'b1);
    chk(csr, 24'h8103);
    @(posedge mclk);
    rst_n <= 1'b0;
    step(3);
    chk(csr, 24'h0);
    chk(wakeLine, 1'b1);
    @(posedge mclk);
    rst_n <= 1'b1;
    step(1);
    complete_run();
  end
endmodule : tb_pmw_power_wake

`default_nettype wire
